/* File: core/gdc_pkg.sv */
// Package for the gate drive configuration bank: offsets, layouts, timing.
// Assumes a single 20 MHz core clock and a plain strobe register port.
`default_nettype none

package gdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;   // Core clock rate
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned FILT_NS0 = 200;        // Overcurrent filter, code 0
  localparam int unsigned FILT_NS1 = 600;        // Code 1
  localparam int unsigned FILT_NS2 = 1200;       // Code 2
  localparam int unsigned FILT_NS3 = 1600;       // Code 3
  localparam int unsigned RETRY_MS = 500;        // Auto retry wait
  localparam int unsigned RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
  localparam int unsigned FILT_W = 6;            // Filter counter width

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic logic [FILT_W-1:0] ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) c = 1;
    return c[FILT_W-1:0];
  endfunction

  localparam logic [FILT_W-1:0] FILT_CYC0 = ns_to_cyc(FILT_NS0);
  localparam logic [FILT_W-1:0] FILT_CYC1 = ns_to_cyc(FILT_NS1);
  localparam logic [FILT_W-1:0] FILT_CYC2 = ns_to_cyc(FILT_NS2);
  localparam logic [FILT_W-1:0] FILT_CYC3 = ns_to_cyc(FILT_NS3);

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CFG_A = 8'hac;   // drive_config_a
  localparam logic [ADDR_W-1:0] ADDR_CFG_B = 8'hae;   // drive_config_b
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'hb0;  // Fault status
  localparam logic [31:0] CFG_A_RESET = 32'h10228100;
  localparam logic [31:0] CFG_B_RESET = 32'h01200000;
  localparam logic [31:0] CFG_A_MASK = 32'h8c0c3703;  // Writable bits
  localparam logic [31:0] CFG_B_MASK = 32'hfdfe0000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // drive_config_a fields
  localparam int unsigned CHK_BIT = 31;
  localparam int unsigned SLEW_LSB = 26;
  localparam int unsigned OVSEL_BIT = 19;
  localparam int unsigned OVEN_BIT = 18;
  localparam int unsigned FILT_LSB = 12;
  localparam int unsigned OCSEL_BIT = 10;
  localparam int unsigned RESP_LSB = 8;
  localparam int unsigned GAIN_LSB = 0;
  // drive_config_b fields
  localparam int unsigned DCOMP_BIT = 30;
  localparam int unsigned TGT_LSB = 26;
  localparam int unsigned SEQ_BIT = 24;
  localparam int unsigned CL_BIT = 23;
  localparam int unsigned VSEL_LSB = 21;
  localparam int unsigned ROFF_BIT = 20;
  localparam int unsigned MINON_LSB = 17;
  // Status fields
  localparam int unsigned ST_OC_ACT = 0;
  localparam int unsigned ST_OC_LATCH = 1;
  localparam int unsigned ST_OV_SEEN = 2;
  localparam int unsigned ST_OV_ACT = 3;

  // Field codes
  localparam logic [1:0] SLEW_RES_MAX = 2'h1;    // Codes at or below are reserved
  localparam logic [1:0] RESP_LATCH = 2'h0;
  localparam logic [1:0] RESP_RETRY = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    OC_CLEAR   = 2'b00,
    OC_LATCHED = 2'b01,
    OC_RETRY   = 2'b10
  } gdc_oc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gdc_bus_req_t;

  typedef struct packed {
    logic [31:0] cfg_a;
    logic [31:0] cfg_b;
    logic [31:0] rdata;
    logic ov_fault;
    logic ov_seen;
    logic [1:0] gain;
  } gdc_bank_t;

endpackage

`default_nettype wire

/* File: core/gdc_oc_fault.sv */
// Overcurrent filter and fault response unit.
// Assumes the raw comparator is synchronous to the core clock.
`default_nettype none

module gdc_oc_fault
  import gdc_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic oc_raw_i,             // Raw overcurrent level
  input wire logic [FILT_W-1:0] filt_cyc_i,
  input wire logic [1:0] response_i,     // Latch or retry
  input wire logic clear_i,              // Clears a latched fault
  output logic fault_o,
  output logic latched_o
);

  typedef struct packed {
    gdc_oc_state_t state;
    logic [FILT_W-1:0] filt_cnt;
    logic [CNT_W-1:0] retry_cnt;
  } gdc_oc_q_t;

  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES - 1);
  localparam logic [FILT_W-1:0] FILT_ONE = FILT_W'(1);

  gdc_oc_q_t s_q;
  gdc_oc_q_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    unique case (s_q.state)
      OC_CLEAR: begin
        // Count consecutive high cycles; any low restarts the filter
        if (oc_raw_i) begin
          s_d.filt_cnt = s_q.filt_cnt + FILT_ONE;
          if (s_q.filt_cnt + FILT_ONE >= filt_cyc_i) begin
            s_d.filt_cnt = '0;
            s_d.retry_cnt = '0;
            if (response_i == RESP_LATCH) begin
              s_d.state = OC_LATCHED;
            end else begin
              s_d.state = OC_RETRY;
            end
          end
        end else begin
          s_d.filt_cnt = '0;
        end
      end
      OC_LATCHED: begin
        // Held until software clears it
        if (clear_i) begin
          s_d.state = OC_CLEAR;
        end
      end
      OC_RETRY: begin
        // Fixed wait, then resume checking
        s_d.retry_cnt = s_q.retry_cnt + CNT_W'(1);
        if (s_q.retry_cnt == RETRY_LAST) begin
          s_d.state = OC_CLEAR;
          s_d.retry_cnt = '0;
        end
      end
      default: begin
        s_d.state = OC_CLEAR;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{state: OC_CLEAR, filt_cnt: '0, retry_cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign fault_o = (s_q.state != OC_CLEAR);
  assign latched_o = (s_q.state == OC_LATCHED);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  filter_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(fault_o) |-> $past(oc_raw_i) && $past(s_q.filt_cnt) == $past(filt_cyc_i) - FILT_ONE)
    else $error("Fault raised before filter time");
  latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    latched_o && !clear_i |=> latched_o)
    else $error("Latched fault dropped without clear");
  retry_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_q.state == OC_CLEAR ##1 s_q.state == OC_RETRY |-> $past(response_i) != RESP_LATCH)
    else $error("Retry entered in latch response");
  retry_cover_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    s_q.state == OC_RETRY ##1 s_q.state == OC_CLEAR);
  latch_cover_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    latched_o ##1 !fault_o);

endmodule

`default_nettype wire

/* File: core/gdc_drive_cfg.sv */
// Gate drive configuration register bank with overcurrent/overvoltage logic.
// Assumes a plain strobe register port and synchronous comparator inputs.
//
// Contract
// - Config A resets to 10228100h, retry response
// - Config B resets to 01200000h
// - Edge rate codes 2/3 only; 0/1 reserved (reset loads code 0)
// - Overvoltage select: 34 V clear, 22 V set
// - Overvoltage checked only while enable bit set
// - Overcurrent must persist filter time first
// - Overcurrent threshold: 9 A clear, 13 A set
// - Response zero latches fault until cleared
// - Response one retries after 500 ms
// - Gain codes select four sense gains
// - Programmed gain used only without auto switching
// - Sequencing-off bit resets one, write-one clears
// - Regulator voltage select, four levels
// - Delay compensation enable with target field
// - Minimum low-side on time field
//
// The address-and-strobe port was decided locally.
`default_nettype none

module gdc_drive_cfg
  import gdc_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,  // Shorten for simulation
  parameter int unsigned RETRY_W = 24               // Retry counter width
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic OC_RAW_I,
  input wire logic OV_RAW_I,
  input wire logic AUTO_GAIN_ON_I,
  input wire logic [1:0] AUTO_GAIN_I,
  output logic [1:0] SLEW_RATE_O,
  output logic OV_THRESH_SEL_O,
  output logic OV_FAULT_O,
  output logic OC_THRESH_SEL_O,
  output logic OC_FAULT_O,
  output logic [1:0] SENSE_GAIN_O,
  output logic DELAY_COMP_ON_O,
  output logic [3:0] TARGET_DELAY_O,
  output logic SEQ_OFF_O,
  output logic CUR_LIMIT_SEL_O,
  output logic [1:0] REG_VSEL_O,
  output logic REG_OFF_O,
  output logic [2:0] MIN_ON_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge a write into the writable bits only
  function automatic logic [31:0] merge_w(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction

  // Read view: writable bits from store, fixed bits from the reset word
  function automatic logic [31:0] view(input logic [31:0] stored,
                                       input logic [31:0] mask,
                                       input logic [31:0] rst);
    return (stored & mask) | (rst & ~mask);
  endfunction

  // Filter code to cycle count
  function automatic logic [FILT_W-1:0] filt_sel(input logic [1:0] code);
    logic [FILT_W-1:0] c;
    unique case (code)
      2'h0: c = FILT_CYC0;
      2'h1: c = FILT_CYC1;
      2'h2: c = FILT_CYC2;
      2'h3: c = FILT_CYC3;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  gdc_bank_t s_q;         // All bank state
  gdc_bank_t s_d;         // Next state
  gdc_bus_req_t req;      // Bundled bus request
  logic [31:0] cfg_a_rd;  // Read view of config A
  logic [31:0] cfg_b_rd;  // Read view of config B
  logic [31:0] status_rd; // Status word
  logic oc_fault;         // From fault unit
  logic oc_latched;       // Latched fault active
  logic oc_clear;         // Software clear of latched fault
  logic wr_a;             // Write to config A
  logic wr_b;             // Write to config B
  logic wr_st;            // Write to status
  logic [1:0] wslew;      // Slew code being written
  logic [1:0] wresp;      // Response code being written

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign wr_a = req.wr && (req.addr == ADDR_CFG_A);
  assign wr_b = req.wr && (req.addr == ADDR_CFG_B);
  assign wr_st = req.wr && (req.addr == ADDR_STATUS);
  assign wslew = req.wdata[SLEW_LSB +: 2];
  assign wresp = req.wdata[RESP_LSB +: 2];

  // Written reserved bits never reach the store; reads show the reset word there
  assign cfg_a_rd = view(s_q.cfg_a, CFG_A_MASK, CFG_A_RESET);
  assign cfg_b_rd = view(s_q.cfg_b, CFG_B_MASK, CFG_B_RESET);

  // Status word, upper bits zero
  always_comb begin
    status_rd = WORD_ZERO;
    status_rd[ST_OC_ACT] = oc_fault;
    status_rd[ST_OC_LATCH] = oc_latched;
    status_rd[ST_OV_SEEN] = s_q.ov_seen;
    status_rd[ST_OV_ACT] = s_q.ov_fault;
  end

  // Writing one to the latch bit releases a latched overcurrent
  assign oc_clear = wr_st && req.wdata[ST_OC_LATCH];

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the bank
  always_comb begin
    s_d = s_q;

    // Config A write; reserved codes leave the old field in place
    if (wr_a) begin
      s_d.cfg_a = merge_w(s_q.cfg_a, req.wdata, CFG_A_MASK);
      if (wslew <= SLEW_RES_MAX) begin
        s_d.cfg_a[SLEW_LSB +: 2] = s_q.cfg_a[SLEW_LSB +: 2];
      end
      if (wresp != RESP_LATCH && wresp != RESP_RETRY) begin
        s_d.cfg_a[RESP_LSB +: 2] = s_q.cfg_a[RESP_LSB +: 2];
      end
    end

    // Config B write; sequencing bit is write-one-to-clear
    if (wr_b) begin
      s_d.cfg_b = merge_w(s_q.cfg_b, req.wdata, CFG_B_MASK);
      s_d.cfg_b[SEQ_BIT] = s_q.cfg_b[SEQ_BIT] & ~req.wdata[SEQ_BIT];
    end

    // Overvoltage check gated by its enable
    s_d.ov_fault = OV_RAW_I && s_q.cfg_a[OVEN_BIT];

    // Sticky overvoltage flag; a new event beats the clear
    if (wr_st && req.wdata[ST_OV_SEEN]) begin
      s_d.ov_seen = 1'b0;
    end
    if (s_q.ov_fault) begin
      s_d.ov_seen = 1'b1;
    end

    // Programmed gain only while auto switching is off
    if (AUTO_GAIN_ON_I) begin
      s_d.gain = AUTO_GAIN_I;
    end else begin
      s_d.gain = s_q.cfg_a[GAIN_LSB +: 2];
    end

    // Read data stands only in the cycle after the strobe
    s_d.rdata = WORD_ZERO;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_CFG_A: s_d.rdata = cfg_a_rd;
        ADDR_CFG_B: s_d.rdata = cfg_b_rd;
        ADDR_STATUS: s_d.rdata = status_rd;
        default: s_d.rdata = WORD_ZERO;  // Unmapped reads as zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank register
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_q.cfg_a <= CFG_A_RESET;
      s_q.cfg_b <= CFG_B_RESET;
      s_q.rdata <= WORD_ZERO;
      s_q.ov_fault <= 1'b0;
      s_q.ov_seen <= 1'b0;
      s_q.gain <= CFG_A_RESET[GAIN_LSB +: 2];
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent filter and response
  gdc_oc_fault #(
    .RETRY_CYCLES(RETRY_CYCLES),
    .CNT_W(RETRY_W)
  ) u_oc (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .oc_raw_i(OC_RAW_I),
    .filt_cyc_i(filt_sel(s_q.cfg_a[FILT_LSB +: 2])),
    .response_i(s_q.cfg_a[RESP_LSB +: 2]),
    .clear_i(oc_clear),
    .fault_o(oc_fault),
    .latched_o(oc_latched)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign RDATA_O = s_q.rdata;
  assign SLEW_RATE_O = s_q.cfg_a[SLEW_LSB +: 2];
  assign OV_THRESH_SEL_O = s_q.cfg_a[OVSEL_BIT];
  assign OV_FAULT_O = s_q.ov_fault;
  assign OC_THRESH_SEL_O = s_q.cfg_a[OCSEL_BIT];
  assign OC_FAULT_O = oc_fault;
  assign SENSE_GAIN_O = s_q.gain;
  assign DELAY_COMP_ON_O = s_q.cfg_b[DCOMP_BIT];
  assign TARGET_DELAY_O = s_q.cfg_b[TGT_LSB +: 4];
  assign SEQ_OFF_O = s_q.cfg_b[SEQ_BIT];
  assign CUR_LIMIT_SEL_O = s_q.cfg_b[CL_BIT];
  assign REG_VSEL_O = s_q.cfg_b[VSEL_LSB +: 2];
  assign REG_OFF_O = s_q.cfg_b[ROFF_BIT];
  assign MIN_ON_O = s_q.cfg_b[MINON_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  read_a_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    RD_I && ADDR_I == ADDR_CFG_A |=> RDATA_O == $past(cfg_a_rd))
    else $error("Config A read data wrong");
  read_only_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    ($past(RD_I) && $past(ADDR_I) == ADDR_CFG_B) |->
      (RDATA_O & ~(CFG_B_MASK | CFG_B_RESET)) == WORD_ZERO)
    else $error("Reserved config B bit read nonzero");
  seq_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    wr_b && WDATA_I[SEQ_BIT] |=> !SEQ_OFF_O ##1 !SEQ_OFF_O)
    else $error("Sequencing bit not cleared by write one");
  slew_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    wr_a && wslew <= SLEW_RES_MAX |=> $stable(SLEW_RATE_O))
    else $error("Reserved slew code stored");
  ov_gate_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    OV_FAULT_O |-> $past(OV_RAW_I) && $past(s_q.cfg_a[OVEN_BIT]))
    else $error("Overvoltage flagged while disabled");
  gain_sel_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    !AUTO_GAIN_ON_I |=> SENSE_GAIN_O == $past(s_q.cfg_a[GAIN_LSB +: 2]))
    else $error("Programmed gain not applied");
  check_bit_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    wr_a |=> s_q.cfg_a[CHK_BIT] == $past(WDATA_I[CHK_BIT]))
    else $error("Check bit not stored");
  ov_sticky_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    OV_FAULT_O |=> s_q.ov_seen)
    else $error("Overvoltage event lost");
  seq_cover_c: cover property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    SEQ_OFF_O ##1 !SEQ_OFF_O);
  status_cover_c: cover property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    RD_I && ADDR_I == ADDR_STATUS && oc_latched);

endmodule

`default_nettype wire

/* File: bench/gdc_drive_cfg_tb_top.sv */
// Self-checking bench for the gate drive configuration bank.
// Assumes gdc_pkg and gdc_drive_cfg are compiled first; drives all ports itself.
`default_nettype none

// Compare two values, count it, report a mismatch at once
`define CHK(what, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); \
  end \
end

module gdc_drive_cfg_tb_top
  import gdc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Settings and signals
  localparam int PERIOD_NS = 50;    // 20 MHz core clock
  localparam int RETRY_SIM = 16;    // Short retry wait keeps the run brief
  int filt_ns[4] = '{200, 600, 1200, 1600};  // Filter spans per code
  int num_errors = 0;
  int n_checks = 0;
  int c;
  int n;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;               // Active low
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic oc_raw = 1'b0;
  logic ov_raw = 1'b0;
  logic auto_on = 1'b0;
  logic [1:0] auto_gain = 2'h0;
  logic [31:0] rdata, sh_a, sh_b, rd_v;
  logic [1:0] slew, gain, vsel;
  logic ov_sel, ov_fault, oc_sel, oc_fault, dcomp, seq_off, cl_sel, reg_off;
  logic [3:0] tgt;
  logic [2:0] min_on;

  ////////////////////////////////////////////////////////////////////////////
  // Design under test, retry wait shortened
  gdc_drive_cfg #(.RETRY_CYCLES(RETRY_SIM), .RETRY_W(24)) u_gdc_drive_cfg (
    .CORE_CLK_I(core_clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .OC_RAW_I(oc_raw), .OV_RAW_I(ov_raw),
    .AUTO_GAIN_ON_I(auto_on), .AUTO_GAIN_I(auto_gain), .SLEW_RATE_O(slew),
    .OV_THRESH_SEL_O(ov_sel), .OV_FAULT_O(ov_fault), .OC_THRESH_SEL_O(oc_sel),
    .OC_FAULT_O(oc_fault), .SENSE_GAIN_O(gain), .DELAY_COMP_ON_O(dcomp),
    .TARGET_DELAY_O(tgt), .SEQ_OFF_O(seq_off), .CUR_LIMIT_SEL_O(cl_sel),
    .REG_VSEL_O(vsel), .REG_OFF_O(reg_off), .MIN_ON_O(min_on)
  );

  // Free-running core clock
  always #(PERIOD_NS / 2) core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Expected register contents
  // Writable bits of config A; reserved bits set in the reset word read as fixed ones
  function automatic logic [31:0] next_a(input logic [31:0] old, input logic [31:0] w);
    logic [31:0] v;
    v = (w & CFG_A_MASK) | (CFG_A_RESET & ~CFG_A_MASK);
    if (w[27:26] < 2'h2) v[27:26] = old[27:26];  // Reserved edge codes refused
    if (w[9:8] > 2'h1) v[9:8] = old[9:8];        // Reserved response codes refused
    return v;
  endfunction

  // Config B: bit 24 only ever cleared, by writing one
  function automatic logic [31:0] next_b(input logic [31:0] old, input logic [31:0] w);
    logic [31:0] v;
    v = w & 32'hfcfe0000;
    v[24] = old[24] & ~w[24];
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus and wait tasks
  task automatic cycles(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data only in the following cycle
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Write config A, read it back and look at its outputs
  task automatic set_a(input logic [31:0] w);
    bus_wr(ADDR_CFG_A, w);
    sh_a = next_a(sh_a, w);
    bus_rd(ADDR_CFG_A, rd_v);
    `CHK("drive_config_a", sh_a, rd_v)
    `CHK("slew rate", sh_a[27:26], slew)
    `CHK("ov threshold", sh_a[19], ov_sel)
    `CHK("oc threshold", sh_a[10], oc_sel)
    `CHK("sense gain", auto_on ? auto_gain : sh_a[1:0], gain)
  endtask

  // Write config B, read it back and look at its outputs
  task automatic set_b(input logic [31:0] w);
    bus_wr(ADDR_CFG_B, w);
    sh_b = next_b(sh_b, w);
    bus_rd(ADDR_CFG_B, rd_v);
    `CHK("drive_config_b", sh_b, rd_v)
    `CHK("regulator outputs", {sh_b[30:26], sh_b[24:17]},
         {dcomp, tgt, seq_off, cl_sel, vsel, reg_off, min_on})
  endtask

  // Overcurrent held high for k samples
  task automatic oc_pulse(input int k);
    @(posedge core_clk);
    oc_raw <= 1'b1;
    repeat (k) @(posedge core_clk);
    oc_raw <= 1'b0;
    #1;
  endtask

  // Bounded wait for a fault level; k counts the edges taken
  task automatic wait_oc(input logic v, input int lim, output int k);
    k = 0;
    while (oc_fault !== v && k <= lim) begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask

  // Single verdict point
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: run needs well under a thousand cycles
  initial begin
    #(PERIOD_NS * 20000);
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    sh_a = 32'h10228100;
    sh_b = 32'h01200000;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset words, read data idle after its cycle, unmapped reads zero
    bus_rd(ADDR_CFG_A, rd_v);
    `CHK("reset drive_config_a", 32'h10228100, rd_v)
    cycles(1);
    `CHK("read data idle", 32'h00000000, rdata)
    bus_rd(ADDR_CFG_B, rd_v);
    `CHK("reset drive_config_b", 32'h01200000, rd_v)
    `CHK("reset regulator pins", 3'b101, {seq_off, vsel})
    bus_rd(8'had, rd_v);
    `CHK("unmapped read", 32'h00000000, rd_v)
    // Every edge code and response codes 0, 1 and 3, reserved ones refused
    set_a(32'hffffffff);
    set_a(32'h04000000);
    set_a(32'h08000300);
    set_a(32'h00000100);
    bus_wr(8'had, 32'h00000000);
    bus_rd(ADDR_CFG_A, rd_v);
    `CHK("after unmapped write", sh_a, rd_v)
    // Regulator register, write-one-clear and all voltage codes
    set_b(32'hffffffff);
    set_b(32'h00000000);
    for (int g = 0; g < 4; g++) set_b({9'h0, g[1:0], 21'h0});
    // Programmed gains, then automatic switching overrides them
    for (int g = 0; g < 4; g++) set_a({22'h0, 2'h1, 6'h0, g[1:0]});
    @(posedge core_clk);
    auto_on <= 1'b1;
    auto_gain <= 2'h2;
    cycles(3);
    `CHK("auto gain", 2'h2, gain)
    set_a(32'h00000103);
    @(posedge core_clk);
    auto_on <= 1'b0;
    cycles(3);
    `CHK("programmed gain back", 2'h3, gain)
    // Overvoltage only counts while enabled
    @(posedge core_clk);
    ov_raw <= 1'b1;
    cycles(3);
    `CHK("ov while disabled", 1'b0, ov_fault)
    set_a(32'h00040100);
    `CHK("ov while enabled", 1'b1, ov_fault)
    bus_rd(ADDR_STATUS, rd_v);
    `CHK("ov status", 2'h3, {rd_v[ST_OV_ACT], rd_v[ST_OV_SEEN]})
    @(posedge core_clk);
    ov_raw <= 1'b0;
    // Sticky flag cleared by writing one once the event is gone
    bus_wr(ADDR_STATUS, 32'h00000004);
    bus_rd(ADDR_STATUS, rd_v);
    `CHK("ov seen cleared", 2'h0, {rd_v[ST_OV_ACT], rd_v[ST_OV_SEEN]})
    // Filter spans per code, with automatic retry
    for (int k = 0; k < 4; k++) begin
      n = filt_ns[k] / PERIOD_NS;
      set_a({18'h0, k[1:0], 12'h100});
      oc_pulse(n - 1);
      cycles(3);
      `CHK("fault after short pulse", 1'b0, oc_fault)
      oc_pulse(n);
      wait_oc(1'b1, 3, c);
      `CHK("fault after full pulse", 1'b1, oc_fault)
      wait_oc(1'b0, RETRY_SIM + 4, c);
      `CHK("retry span", RETRY_SIM, c)
    end
    // Latched response holds until cleared
    set_a(32'h00000000);
    oc_pulse(filt_ns[0] / PERIOD_NS);
    wait_oc(1'b1, 3, c);
    cycles(RETRY_SIM + 8);
    `CHK("latched fault", 1'b1, oc_fault)
    bus_rd(ADDR_STATUS, rd_v);
    `CHK("oc status", 2'h3, {rd_v[ST_OC_LATCH], rd_v[ST_OC_ACT]})
    bus_wr(ADDR_STATUS, 32'h00000002);
    cycles(1);
    `CHK("fault cleared", 1'b0, oc_fault)
    // Mid-run reset: defaults return, and writing zero leaves bit 24 set
    @(posedge core_clk);
    rst_n <= 1'b0;
    cycles(2);
    @(posedge core_clk);
    rst_n <= 1'b1;
    sh_a = CFG_A_RESET;
    sh_b = CFG_B_RESET;
    bus_rd(ADDR_CFG_A, rd_v);
    `CHK("second reset drive_config_a", CFG_A_RESET, rd_v)
    set_b(32'h00000000);
    finish_test();
  end

endmodule

`default_nettype wire
